/* sirq_top.sv */
// Status register, interrupt flags and enables, interrupt pin control.
// Assumes an AXI4-Lite master on the same clock; event and status inputs
// come from other clock domains or pins and are synchronised here.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

// How it works
// [RULE_01] Status low byte at 0xFFFC, high byte 0xFFFD; bits 0,1,2 defined.
// [RULE_02] Writable bit reads 1 when host may write message memory; resets 0.
// [RULE_03] Bit 1 reads 1 while a checksum runs; resets 0.
// [RULE_04] Bit 2 reads 1 while radio traffic is active; resets 0.
// [RULE_05] Enable register sits at 0xFFFA low and 0xFFFB high.
// [RULE_06] Enable 1 lets its event reach the pin; 0 blocks; reset 0.
// [RULE_07] Pending flags gated by enables are ORed onto one interrupt.
// [RULE_08] Flag register sits at 0xFFF8 low and 0xFFF9 high.
// [RULE_09] Flag reads 1 when pending, 0 otherwise; reset 0.
// [RULE_10] Writing 1 clears a flag; writing 0 leaves it.
// [RULE_11] Read-complete flag bit 1 set when field drops after a read.
// [RULE_12] Write-complete flag bit 2 set when field drops after a write.
// [RULE_13] Checksum-done flag bit 3 set when a calculation finishes.
// [RULE_14] Parity-fault flag bit 4 set on parity error, only in parity mode.
// [RULE_15] Message-fault flag bit 5 set on bad structure after radio enable.
// [RULE_16] General fault flag bit 7 set on any disabling error.
// [RULE_17] Output enable 0 leaves the pin undriven; 1 signals interrupts.
// [RULE_18] Control bit 3 selects active high when 1, active low when 0.
// [RULE_19] Control bit 4 drives idle level when 1, else pin floats idle.
// [RULE_20] An event in the clearing cycle keeps its flag set.
// [RULE_21] Reserved bits read zero and ignore writes.
module sirq_top
    import sirq_pkg::*;
#(
    parameter int ADDR_WIDTH = 18
) (
    input wire logic clock,
    input wire logic reset_n,
    // AXI4-Lite slave
    input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Status levels from the rest of the device
    input wire logic message_store_writable,
    input wire logic checksum_running,
    input wire logic radio_activity,
    // Event pulses (held at least two clocks) from the rest of the device
    input wire logic read_complete_event,
    input wire logic write_complete_event,
    input wire logic checksum_done_event,
    input wire logic parity_fault_event,
    input wire logic message_structure_fault_event,
    input wire logic general_fault_event,
    // Interrupt pin
    output logic irq_pin_out,
    output logic irq_pin_oe,
    // Mode output
    output logic interleaved_parity_mode
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Word index of a byte address; each register byte sits in its own word
    function automatic logic [15:0] sirq_word(input logic [ADDR_WIDTH-1:0] a);
        sirq_word = 16'(a >> 2);
    endfunction

    function automatic logic [15:0] sirq_idx(input logic [15:0] a);
        sirq_idx = a;
    endfunction

    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    logic [8:0] sync_raw;
    logic [8:0] sync_lvl;
    assign sync_raw = {general_fault_event, message_structure_fault_event,
        parity_fault_event, checksum_done_event, write_complete_event,
        read_complete_event, radio_activity, checksum_running,
        message_store_writable};

    sirq_sync #(
        .WIDTH(9)
    ) u_sync (
        .clock(clock),
        .reset_n(reset_n),
        .async_in(sync_raw),
        .sync_out(sync_lvl)
    );

    logic [5:0] ev_prev_q;
    wire [5:0] ev_lvl = sync_lvl[8:3];
    wire [5:0] ev_rise = ev_lvl & ~ev_prev_q;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [15:0] status_q;
    logic [15:0] flags_q;
    logic [15:0] flags_d;
    logic [15:0] enable_q;
    logic [15:0] enable_d;
    logic [15:0] ctl_q;
    logic [15:0] ctl_d;
    logic irq_q;

    logic [15:0] status_d;
    assign status_d = {13'h0000, sync_lvl[2], sync_lvl[1], sync_lvl[0]}; // [RULE_02] [RULE_03] [RULE_04]

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    logic aw_held_q;
    logic w_held_q;
    logic [15:0] aw_word_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;

    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire wr_fire = aw_held_q & w_held_q & ~s_axi_bvalid;
    wire wr_lane0 = w_strb_q[0];
    wire [7:0] wr_byte = w_data_q[7:0];
    wire aw_held_d = aw_take | (aw_held_q & ~wr_fire);
    wire w_held_d = w_take | (w_held_q & ~wr_fire);
    wire bvalid_d = wr_fire | (s_axi_bvalid & ~s_axi_bready);

    wire wr_flags_lo = wr_fire & (aw_word_q == SIRQ_FLAGS_LO_ADDR);
    wire wr_flags_hi = wr_fire & (aw_word_q == SIRQ_FLAGS_HI_ADDR);
    wire wr_en_lo = wr_fire & (aw_word_q == SIRQ_ENABLE_LO_ADDR);
    wire wr_en_hi = wr_fire & (aw_word_q == SIRQ_ENABLE_HI_ADDR);
    wire wr_st_lo = wr_fire & (aw_word_q == SIRQ_STATUS_LO_ADDR);
    wire wr_st_hi = wr_fire & (aw_word_q == SIRQ_STATUS_HI_ADDR);
    wire wr_ctl = wr_fire & (aw_word_q == SIRQ_CONTROL_ADDR);
    wire wr_hit = wr_flags_lo | wr_flags_hi | wr_en_lo | wr_en_hi | wr_st_lo | wr_st_hi
        | wr_ctl; // [RULE_01] [RULE_05] [RULE_08]

    // Clear mask from a write-one-to-clear byte
    logic [15:0] clr_mask;
    assign clr_mask = (wr_flags_lo & wr_lane0) ? {8'h00, wr_byte} :
        (wr_flags_hi & wr_lane0) ? {wr_byte, 8'h00} : 16'h0000; // [RULE_10]

    // Event set vector; parity faults only count in parity mode
    logic [15:0] set_mask;
    assign set_mask = {8'h00,
        ev_rise[5], 1'b0, ev_rise[4],
        ev_rise[3] & ctl_q[SIRQ_CTL_PARITY_MODE_BIT],
        ev_rise[2], ev_rise[1], ev_rise[0], 1'b0}; // [RULE_11] [RULE_12] [RULE_13] [RULE_14] [RULE_15] [RULE_16]

    // Set wins over clear
    assign flags_d = ((flags_q & ~clr_mask) | set_mask) & SIRQ_EVENT_MASK; // [RULE_09] [RULE_20] [RULE_21]

    assign enable_d = (wr_en_lo & wr_lane0) ? {enable_q[15:8], wr_byte} & SIRQ_EVENT_MASK :
        (wr_en_hi & wr_lane0) ? {wr_byte, enable_q[7:0]} & SIRQ_EVENT_MASK :
        enable_q; // [RULE_06] [RULE_21]

    assign ctl_d = (wr_ctl & wr_lane0) ? {8'h00, wr_byte} & SIRQ_CTL_MASK : ctl_q;

    wire irq_d = |(flags_q & enable_q); // [RULE_07]

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_word_q <= 16'h0000;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= SIRQ_RESP_OKAY;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end
        else
        begin
            s_axi_awready <= ~aw_held_d & ~bvalid_d;
            s_axi_wready <= ~w_held_d & ~bvalid_d;
            if (aw_take)
            begin
                aw_held_q <= 1'b1;
                aw_word_q <= sirq_word(s_axi_awaddr);
            end
            else if (wr_fire)
                aw_held_q <= 1'b0;
            if (w_take)
            begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            else if (wr_fire)
                w_held_q <= 1'b0;
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? SIRQ_RESP_OKAY : SIRQ_RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end


    // ------------------------------------------------------------
    // Block state
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ev_prev_q <= 6'h00;
            status_q <= SIRQ_STATUS_RESET;
            flags_q <= SIRQ_FLAGS_RESET;
            enable_q <= SIRQ_ENABLE_RESET;
            ctl_q <= SIRQ_CTL_RESET;
            irq_q <= 1'b0;
            interleaved_parity_mode <= 1'b0;
        end
        else
        begin
            ev_prev_q <= ev_lvl;
            status_q <= status_d;
            flags_q <= flags_d;
            enable_q <= enable_d;
            ctl_q <= ctl_d;
            irq_q <= irq_d;
            interleaved_parity_mode <= ctl_d[SIRQ_CTL_PARITY_MODE_BIT];
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    wire [15:0] rd_word = sirq_word(s_axi_araddr);
    wire rd_take = s_axi_arvalid & s_axi_arready;
    wire rvalid_d = rd_take | (s_axi_rvalid & ~s_axi_rready);
    wire [15:0] fl_lo = sirq_idx(SIRQ_FLAGS_LO_ADDR);
    logic [7:0] rd_byte;
    logic rd_hit;
    always_comb
    begin
        rd_hit = 1'b1;
        if (rd_word == fl_lo)
            rd_byte = flags_q[7:0];
        else if (rd_word == SIRQ_FLAGS_HI_ADDR)
            rd_byte = flags_q[15:8];
        else if (rd_word == SIRQ_ENABLE_LO_ADDR)
            rd_byte = enable_q[7:0];
        else if (rd_word == SIRQ_ENABLE_HI_ADDR)
            rd_byte = enable_q[15:8];
        else if (rd_word == SIRQ_STATUS_LO_ADDR)
            rd_byte = status_q[7:0];
        else if (rd_word == SIRQ_STATUS_HI_ADDR)
            rd_byte = status_q[15:8];
        else if (rd_word == SIRQ_CONTROL_ADDR)
            rd_byte = ctl_q[7:0];
        else
        begin
            rd_byte = 8'h00;
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= SIRQ_RESP_OKAY;
        end
        else if (rd_take)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte}; // [RULE_21]
            s_axi_rresp <= rd_hit ? SIRQ_RESP_OKAY : SIRQ_RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            s_axi_arready <= 1'b1;
        else
            s_axi_arready <= ~rvalid_d;
    end

    // ------------------------------------------------------------
    // Interrupt pin
    // ------------------------------------------------------------
    sirq_pin u_pin (
        .clock(clock),
        .reset_n(reset_n),
        .irq_request(irq_q),
        .out_enable(ctl_q[SIRQ_CTL_OUT_EN_BIT]),
        .active_high(ctl_q[SIRQ_CTL_HIGH_BIT]),
        .drive_idle(ctl_q[SIRQ_CTL_DRIVE_BIT]),
        .pin_out_q(irq_pin_out),
        .pin_oe_q(irq_pin_oe)
    );
endmodule
`default_nettype wire

/* sirq_pkg.sv */
// Shared constants of the status and interrupt block: register map,
// field positions and reset values.
// Assumes a 32-bit AXI4-Lite register bus, one register byte per aligned word.
package sirq_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [15:0] SIRQ_FLAGS_LO_ADDR = 16'hfff8;
    localparam logic [15:0] SIRQ_FLAGS_HI_ADDR = 16'hfff9;
    localparam logic [15:0] SIRQ_ENABLE_LO_ADDR = 16'hfffa;
    localparam logic [15:0] SIRQ_ENABLE_HI_ADDR = 16'hfffb;
    localparam logic [15:0] SIRQ_STATUS_LO_ADDR = 16'hfffc;
    localparam logic [15:0] SIRQ_STATUS_HI_ADDR = 16'hfffd;
    localparam logic [15:0] SIRQ_CONTROL_ADDR = 16'hfff0;

    // ------------------------------------------------------------
    // Status fields
    // ------------------------------------------------------------
    localparam int SIRQ_ST_WRITABLE_BIT = 0;
    localparam int SIRQ_ST_CHECKSUM_BIT = 1;
    localparam int SIRQ_ST_RADIO_BIT = 2;
    localparam logic [15:0] SIRQ_STATUS_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Interrupt fields
    // ------------------------------------------------------------
    localparam int SIRQ_EV_READ_DONE_BIT = 1;
    localparam int SIRQ_EV_WRITE_DONE_BIT = 2;
    localparam int SIRQ_EV_CHECKSUM_BIT = 3;
    localparam int SIRQ_EV_PARITY_BIT = 4;
    localparam int SIRQ_EV_MSG_FAULT_BIT = 5;
    localparam int SIRQ_EV_GENERAL_BIT = 7;
    localparam logic [15:0] SIRQ_EVENT_MASK = 16'h00be;
    localparam logic [15:0] SIRQ_FLAGS_RESET = 16'h0000;
    localparam logic [15:0] SIRQ_ENABLE_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Control register fields: pin control and parity mode
    // ------------------------------------------------------------
    localparam int SIRQ_CTL_OUT_EN_BIT = 1;
    localparam int SIRQ_CTL_HIGH_BIT = 3;
    localparam int SIRQ_CTL_DRIVE_BIT = 4;
    localparam int SIRQ_CTL_PARITY_MODE_BIT = 5;
    localparam logic [15:0] SIRQ_CTL_MASK = 16'h003a;
    localparam logic [15:0] SIRQ_CTL_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------
    localparam logic [1:0] SIRQ_RESP_OKAY = 2'h0;
    localparam logic [1:0] SIRQ_RESP_SLVERR = 2'h2;

endpackage

/* sirq_sync.sv */
// Two-stage synchroniser for a vector of asynchronous levels.
// Assumes inputs come from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module sirq_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_q;

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stage1_q <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage1_q <= async_in;
            sync_out <= stage1_q;
        end
    end
endmodule
`default_nettype wire

/* sirq_pin.sv */
// Interrupt pin driver: polarity, drive style and output enable.
// Assumes the request level is already registered in the same domain.
`timescale 1ns/1ps
`default_nettype none
module sirq_pin (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic irq_request,
    input wire logic out_enable,
    input wire logic active_high,
    input wire logic drive_idle,
    output logic pin_out_q,
    output logic pin_oe_q
);
    wire active_level = active_high;
    wire pin_level = irq_request ? active_level : ~active_level;
    wire pin_drive = out_enable & (irq_request | drive_idle);

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin_out_q <= 1'b0;
            pin_oe_q <= 1'b0;
        end
        else
        begin
            pin_out_q <= pin_level; // [RULE_18]
            pin_oe_q <= pin_drive; // [RULE_17] [RULE_19]
        end
    end
endmodule
`default_nettype wire

/* sirq_host.sv */
// Host microcontroller model: AXI4-Lite master with one write and one read task.
// Assumes the caller enters a task between clock edges or right after one.
`timescale 1ns/1ps
`default_nettype none
module sirq_host (
    input wire logic clock,
    output logic [17:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [17:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    output logic rready,
    output logic hung
);
    initial
    begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready, hung} = '0;
    end

    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    task automatic wr(input logic [17:0] a, input logic [7:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clock);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= 4'h1;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clock);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        while (!bvalid && n < 50);
        r = bresp;
        bready <= 1'b0;
        if (n >= 50) hung <= 1'b1;
    endtask

    task automatic rd(input logic [17:0] a);
        int n;
        n = 0;
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clock);
            n++;
            if (arready) arvalid <= 1'b0;
        end
        while (!rvalid && n < 50);
        rready <= 1'b0;
        if (n >= 50) hung <= 1'b1;
    endtask
endmodule
`default_nettype wire

/* sirq_top_chk.sv */
// Bus and register-content assertions on the ports of sirq_top.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module sirq_top_chk
    import sirq_pkg::*;
#(
    parameter int ADDR_WIDTH = 18
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic irq_pin_oe
);
    localparam logic [ADDR_WIDTH-1:0] ST_LO = ADDR_WIDTH'({SIRQ_STATUS_LO_ADDR, 2'b00});
    localparam logic [ADDR_WIDTH-1:0] ST_HI = ADDR_WIDTH'({SIRQ_STATUS_HI_ADDR, 2'b00});
    localparam logic [ADDR_WIDTH-1:0] FL_LO = ADDR_WIDTH'({SIRQ_FLAGS_LO_ADDR, 2'b00});

    default clocking dcb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    sequence s_rd(logic [ADDR_WIDTH-1:0] a);
        s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
    endsequence
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence

    chk_b_held:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
    chk_r_held:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
    chk_ar_blocked:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted during pending read");
    chk_w_blocked:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during pending response");
    chk_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
    chk_write_answer:
    assert property (s_wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
    chk_status_hi:
    assert property (s_rd(ST_HI) |=> s_axi_rdata == 32'h0 && s_axi_rresp == SIRQ_RESP_OKAY)
    else $error("status high byte not zero");
    chk_status_spare:
    assert property (s_rd(ST_LO) |=> s_axi_rdata[31:3] == 29'h0)
    else $error("status spare bits set");
    chk_flag_spare:
    assert property (s_rd(FL_LO) |=> s_axi_rdata[0] == 1'b0 && s_axi_rdata[6] == 1'b0
        && s_axi_rdata[31:8] == 24'h0)
    else $error("flag spare bits set");
    chk_pin_reset:
    assert property ($rose(reset_n) |-> !irq_pin_oe)
    else $error("pin driven after reset");
endmodule

bind sirq_top sirq_top_chk #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (
    .clock(clock), .reset_n(reset_n), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .irq_pin_oe(irq_pin_oe)
);
`default_nettype wire

/* tb_status_and_irq_logic.sv */
// Self-checking bench for sirq_top: registers, events, interrupt pin.
// Assumes sirq_host drives the register bus and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
module tb_status_and_irq_logic;
    import sirq_pkg::*;
    localparam logic [17:0] A_FLO = {SIRQ_FLAGS_LO_ADDR, 2'b00};
    localparam logic [17:0] A_FHI = {SIRQ_FLAGS_HI_ADDR, 2'b00};
    localparam logic [17:0] A_ELO = {SIRQ_ENABLE_LO_ADDR, 2'b00};
    localparam logic [17:0] A_EHI = {SIRQ_ENABLE_HI_ADDR, 2'b00};
    localparam logic [17:0] A_SLO = {SIRQ_STATUS_LO_ADDR, 2'b00};
    localparam logic [17:0] A_SHI = {SIRQ_STATUS_HI_ADDR, 2'b00};
    localparam logic [17:0] A_CTL = {SIRQ_CONTROL_ADDR, 2'b00};
    logic clock = 1'b0;
    logic reset_n;
    logic [2:0] st;
    logic [5:0] ev;
    logic [17:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, hung, pin_out, pin_oe, par_mode;
    logic [7:0] m, exp;
    logic [33:0] exp_q[$];
    logic [17:0] regs [7] = '{A_FLO, A_FHI, A_ELO, A_EHI, A_SLO, A_SHI, A_CTL};
    logic [7:0] evm [6] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h80};
    logic [7:0] ctl_t [5] = '{8'h00, 8'h02, 8'h0a, 8'h12, 8'h1a};
    int bad_count = 0;
    int n_checks = 0;
    integer seed = 53;

    always #50 clock = ~clock;

    sirq_top #(.ADDR_WIDTH(18)) DUT (
        .clock(clock), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .message_store_writable(st[0]), .checksum_running(st[1]), .radio_activity(st[2]),
        .read_complete_event(ev[0]), .write_complete_event(ev[1]), .checksum_done_event(ev[2]),
        .parity_fault_event(ev[3]), .message_structure_fault_event(ev[4]),
        .general_fault_event(ev[5]), .irq_pin_out(pin_out), .irq_pin_oe(pin_oe),
        .interleaved_parity_mode(par_mode)
    );
    sirq_host host (
        .clock(clock), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rvalid(rvalid), .rready(rready), .hung(hung)
    );

    // ------------------------------------------------------------
    // Checking and helpers
    // ------------------------------------------------------------
    task automatic check(input logic [33:0] seen, input logic [33:0] want);
        n_checks++;
        if (seen !== want)
        begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic rdx(input logic [17:0] a, input logic [7:0] d);
        exp_q.push_back({SIRQ_RESP_OKAY, 24'h0, d});
        host.rd(a);
    endtask

    task automatic pulse(input int i);
        ev[i] <= 1'b1;
        repeat (3) @(posedge clock);
        ev[i] <= 1'b0;
        repeat (8) @(posedge clock);
    endtask

    task automatic pin(input logic en, input logic hi, input logic drv, input logic pend);
        logic oe;
        oe = en && (pend || drv);
        repeat (4) @(posedge clock);
        #1;
        check({32'h0, pin_oe, pin_oe & pin_out}, {32'h0, oe, oe & (pend == hi)});
        @(posedge clock);
    endtask

    always @(posedge clock)
    begin
        if (rvalid && rready && exp_q.size() > 0)
            check({rresp, rdata}, exp_q.pop_front());
    end

    initial
    begin
        wait (hung === 1'b1);
        bad_count++;
        test_done();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        reset_n = 1'b0;
        st = 3'h0;
        ev = 6'h00;
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        foreach (regs[i]) rdx(regs[i], 8'h00);
        exp_q.push_back({SIRQ_RESP_SLVERR, 32'h0});
        host.rd(18'h3fff8);
        host.wr(18'h3fff8, 8'h55, r);
        check({32'h0, r}, {32'h0, SIRQ_RESP_SLVERR});
        for (int i = 0; i < 3; i++)
        begin
            st <= 3'h1 << i;
            repeat (4) @(posedge clock);
            rdx(A_SLO, 8'h01 << i);
        end
        st <= 3'h0;
        host.wr(A_SLO, 8'hff, r);
        repeat (4) @(posedge clock);
        rdx(A_SLO, 8'h00);
        rdx(A_SHI, 8'h00);
        host.wr(A_CTL, 8'h3a, r);
        check({33'h0, par_mode}, {33'h0, 1'b1});
        exp = 8'h00;
        for (int i = 0; i < 6; i++)
        begin
            pulse(i);
            exp = exp | evm[i];
            rdx(A_FLO, exp);
        end
        pin(1'b1, 1'b1, 1'b1, 1'b0);
        for (int i = 0; i < 5; i++)
        begin
            m = 8'($random(seed));
            host.wr(A_ELO, m, r);
            rdx(A_ELO, m & SIRQ_EVENT_MASK[7:0]);
            pin(1'b1, 1'b1, 1'b1, |(m & 8'hbe));
        end
        host.wr(A_EHI, 8'hff, r);
        rdx(A_EHI, 8'h00);
        rdx(A_FHI, 8'h00);
        host.wr(A_FLO, 8'h00, r);
        rdx(A_FLO, 8'hbe);
        host.wr(A_FLO, 8'h0a, r);
        rdx(A_FLO, 8'hb4);
        host.wr(A_FLO, 8'hff, r);
        rdx(A_FLO, 8'h00);
        // Event edge and its clearing write land on the same clock edge
        ev[0] <= 1'b1;
        host.wr(A_FLO, 8'h02, r);
        ev[0] <= 1'b0;
        rdx(A_FLO, 8'h02);
        host.wr(A_FLO, 8'h02, r);
        host.wr(A_ELO, 8'hbe, r);
        for (int p = 0; p < 2; p++)
        begin
            foreach (ctl_t[k])
            begin
                host.wr(A_CTL, ctl_t[k], r);
                pin(ctl_t[k][1], ctl_t[k][3], ctl_t[k][4], p[0]);
            end
            pulse(3);
            pulse(5);
            rdx(A_FLO, 8'h80);
        end
        test_done();
    end
endmodule
`default_nettype wire
